// *** mlpm_assertions.sv ***
/*
  Port-level checker for the motor load protection monitor.
  Assumes zero-wait APB, sticky W1C flags and CPS cycles per second.
*/
`timescale 1ns/100ps
module mlpm_assertions #(
  parameter int unsigned CPS = 10
) (
  input wire logic        I_MCLK,
  input wire logic        I_RESETN,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic        I_FULL_VOLTAGE,
  input wire logic        I_START_PULSE,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_MOTOR_DISABLE,
  input wire logic [5:0]  O_FAULT_FLAGS,
  input wire logic [4:0]  O_ALARM_FLAGS
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  logic [10:0]  prev_r;
  int unsigned  fv_cnt_r;
  logic [10:0]  cur_w;
  logic [10:0]  new_w;
  logic         fell_w;
  logic         w1c_w;
  // flag edges, bits [4:0] faults, [5] rotation, [10:6] alarms
  assign cur_w  = {O_ALARM_FLAGS, O_FAULT_FLAGS};
  assign new_w  = cur_w & ~prev_r;
  assign fell_w = |(prev_r & ~cur_w);
  assign w1c_w  = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR[7:2] == 6'h07);
  // history and armed-time counter; counter never wraps in a short run
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prev_r   <= 11'h000;
      fv_cnt_r <= 0;
    end else begin
      prev_r   <= cur_w;
      fv_cnt_r <= I_FULL_VOLTAGE ? fv_cnt_r + 1 : 0;
    end
  end
  pready_high_a:   assert property (O_PREADY) else $error("pready low");
  slverr_map_a:    assert property (I_PSEL && I_PENABLE |-> O_PSLVERR == (I_PADDR[7:2] > 6'h08))
    else $error("pslverr does not match address map");
  disable_fault_a: assert property (O_MOTOR_DISABLE == (|O_FAULT_FLAGS)) else $error("disable mismatch");
  armed_trip_a:    assert property (|{new_w[10:6], new_w[4:0]} |-> $past(I_FULL_VOLTAGE, 2))
    else $error("trip while not armed");
  persist_time_a:  assert property (|{new_w[10:6], new_w[4:0]} |-> fv_cnt_r >= CPS - 1)
    else $error("trip before persistence time");
  mode_excl_a:     assert property ((new_w[10:6] & new_w[4:0]) == 5'h00)
    else $error("fault and alarm from one protection");
  rot_start_a:     assert property ($rose(O_FAULT_FLAGS[5]) |-> $past(I_START_PULSE))
    else $error("rotation fault without start");
  flag_sticky_a:   assert property (fell_w |-> $past(w1c_w)) else $error("flag fell without clear");
  fault_c: cover property (|new_w[4:0]);
  alarm_c: cover property (|new_w[10:6]);
  rot_c:   cover property (new_w[5]);
  err_c:   cover property (O_PSLVERR);
endmodule : mlpm_assertions

bind mlpm_top mlpm_assertions #(.CPS(CPS)) mlpm_assertions_inst (.I_MCLK, .I_RESETN, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_FULL_VOLTAGE, .I_START_PULSE, .O_PREADY, .O_PSLVERR, .O_MOTOR_DISABLE,
  .O_FAULT_FLAGS, .O_ALARM_FLAGS);

// *** mlpm_front.sv ***
/*
  Behavioural measurement front end and run control of the motor.
  Assumes the testbench calls its tasks; outputs move just after a rising edge.
*/
`timescale 1ns/100ps
module mlpm_front import mlpm_pkg::*; (
  input  wire logic        i_clk,
  // measurements
  output logic [MEAS_W-1:0] o_ir,
  output logic [MEAS_W-1:0] o_is,
  output logic [MEAS_W-1:0] o_it,
  output logic [TQ_W-1:0]   o_tq,
  output logic [MEAS_W-1:0] o_pw,
  // run control
  output logic             o_run,
  output logic             o_fv,
  output logic             o_start,
  output logic             o_rst
);
  // nominal load at rated values, motor stopped
  initial begin
    {o_ir, o_is, o_it, o_pw} = {4{16'h0064}};
    o_tq = 10'h064;
    {o_run, o_fv, o_start, o_rst} = 4'h0;
  end
  task set_load(input logic [15:0] r, s, t, input logic [9:0] q, input logic [15:0] p);
    @(posedge i_clk);
    o_ir <= r;
    o_is <= s;
    o_it <= t;
    o_tq <= q;
    o_pw <= p;
  endtask : set_load
  // one start pulse per start, full voltage only after the ramp
  task motor_start(input logic rst, input logic fv);
    @(posedge i_clk);
    o_run   <= 1'b1;
    o_start <= 1'b1;
    o_rst   <= rst;
    @(posedge i_clk);
    o_start <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_fv    <= fv;
  endtask : motor_start
  task motor_stop;
    @(posedge i_clk);
    o_fv  <= 1'b0;
    o_run <= 1'b0;
  endtask : motor_stop
endmodule : mlpm_front

// *** mlpm_persist.sv ***
/*
  Persistence timer of one protection: counts whole seconds of an
  uninterrupted excursion and pulses once when the set time is reached.
  Assumes the excursion input is already gated by arming and mode.
*/
`timescale 1ns/100ps
module mlpm_persist import mlpm_pkg::*; #(
  parameter int unsigned CPS = CYCLES_PER_SEC
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // excursion and setting
  input  wire logic              i_exceed,
  input  wire logic [TIME_W-1:0] i_time_s,
  // trip event
  output logic                   o_trip
);

  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(CPS - 1);

  logic [SUB_W-1:0]  sub_r;
  logic [TIME_W-1:0] sec_r;
  logic              fired_r;
  logic              trip_r;

  wire               sec_end   = (sub_r == SUB_LAST);
  wire  [TIME_W-1:0] sec_inc   = sec_r + 7'h01;
  wire               time_done = sec_end && (sec_inc >= i_time_s);

  // count only while the excursion lasts; one trip per excursion
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sub_r   <= '0;
      sec_r   <= '0;
      fired_r <= 1'b0;
      trip_r  <= 1'b0;
    end else if (!i_exceed) begin
      sub_r   <= '0;
      sec_r   <= '0;
      fired_r <= 1'b0;
      trip_r  <= 1'b0;
    end else begin
      sub_r   <= (sec_end || fired_r) ? '0 : sub_r + 24'h000001;
      sec_r   <= (sec_end && !fired_r) ? sec_inc : sec_r;
      fired_r <= fired_r | time_done;
      trip_r  <= time_done && !fired_r;
    end
  end

  assign o_trip = trip_r;

endmodule : mlpm_persist

// *** mlpm_pkg.sv ***
/*
  Shared constants for the motor load protection monitor: register map,
  configuration field layout, reset values, trip modes and timing counts.
  Assumes a 10 MHz system clock and a 32-bit APB register bus.
*/
// Functional notes
// - imbalance mode: 0 off, 1 fault disabling motor, 2 alarm only; default 0.
// - imbalance threshold 0..30 percent, default 15; any pair deviation beyond it trips.
// - imbalance persistence 1..99 seconds, default 1.
// - imbalance terms R-S, S-T, T-R, each scaled to rated motor current percent.
// - imbalance held beyond threshold for persistence time triggers the programmed action.
// - fault disables motor and flags a fault; alarm keeps motor running, flags alarm.
// - imbalance protection armed only at full voltage after start completes.
// - low torque mode: 0 off, 1 fault, 2 alarm; default 0.
// - low torque threshold 0..99 percent, default 30; trips below rated by more.
// - low torque persistence 1..99 seconds, default 1.
// - high torque mode: 0 off, 1 fault, 2 alarm; default 0.
// - high torque threshold 0..99 percent, default 30; trips above rated by more.
// - high torque persistence 1..99 seconds, default 1.
// - torque deviation: under is 100 minus percent, over is percent minus 100.
// - low power mode: 0 off, 1 fault, 2 alarm; default 0.
// - low power threshold 0..99 percent default 30; persistence 1..99 s default 1.
// - high power mode: 0 off, 1 fault, 2 alarm; default 0.
// - high power threshold 0..99 percent default 30; persistence 1..99 s default 1.
// - power deviation is (measured minus rated) over rated times 100; sign picks side.
// - torque and power protections armed only at full voltage after start.
// - with rotation check enabled, supply phase order is checked on every start.
// - rotation mode 0 off, 1 allows only RST, 2 allows only RTS; else fault.
package mlpm_pkg;

  // protection slots, also the configuration register index
  localparam int NPROT = 5;
  localparam int P_IMB = 0;
  localparam int P_LTQ = 1;
  localparam int P_HTQ = 2;
  localparam int P_LPW = 3;
  localparam int P_HPW = 4;
  localparam int NFLT  = 6;  // five protections plus rotation order

  // register byte addresses
  localparam logic [7:0] ADDR_IMB_CFG = 8'h00;
  localparam logic [7:0] ADDR_LTQ_CFG = 8'h04;
  localparam logic [7:0] ADDR_HTQ_CFG = 8'h08;
  localparam logic [7:0] ADDR_LPW_CFG = 8'h0C;
  localparam logic [7:0] ADDR_HPW_CFG = 8'h10;
  localparam logic [7:0] ADDR_ROT_CFG = 8'h14;
  localparam logic [7:0] ADDR_RATED   = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1C;
  localparam logic [7:0] ADDR_LIVE    = 8'h20;

  // protection configuration word layout
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_THR_LSB  = 8;
  localparam int CFG_TIME_LSB = 16;
  localparam int MODE_W       = 2;
  localparam int THR_W        = 7;
  localparam int TIME_W       = 7;

  // rated value word layout
  localparam int RATED_I_LSB = 0;
  localparam int RATED_P_LSB = 16;
  localparam int MEAS_W      = 16;
  localparam int TQ_W        = 10;

  // status word layout
  localparam int ST_FAULT_LSB = 0;
  localparam int ST_ALARM_LSB = 8;
  localparam int ST_DIS_BIT   = 16;
  localparam int ST_ARMED_BIT = 17;

  // reset values and limits
  localparam logic [THR_W-1:0]  IMB_THR_DEF = 7'h0F;
  localparam logic [THR_W-1:0]  IMB_THR_MAX = 7'h1E;
  localparam logic [THR_W-1:0]  LD_THR_DEF  = 7'h1E;
  localparam logic [THR_W-1:0]  LD_THR_MAX  = 7'h63;
  localparam logic [TIME_W-1:0] TIME_DEF    = 7'h01;
  localparam logic [TIME_W-1:0] TIME_MIN    = 7'h01;
  localparam logic [TIME_W-1:0] TIME_MAX    = 7'h63;
  localparam logic [MEAS_W-1:0] RATED_I_DEF = 16'h0064;
  localparam logic [MEAS_W-1:0] RATED_P_DEF = 16'h0064;
  localparam logic [23:0]       PCT_SCALE   = 24'h000064;
  localparam logic [TQ_W:0]     PCT_FULL    = 11'h064;

  // timing: persistence counts in whole seconds
  localparam int CLK_PERIOD_NS  = 100;
  localparam int PERSIST_UNIT_S = 1;
  localparam int CYCLES_PER_SEC = PERSIST_UNIT_S * 1000000000 / CLK_PERIOD_NS;
  localparam int SUB_W          = 24;

  // trip action of one protection
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_FAULT = 2'b01,
    MODE_ALARM = 2'b10
  } mlpm_mode_t;

  // allowed supply phase order
  typedef enum logic [1:0] {
    ROT_OFF = 2'b00,
    ROT_RST = 2'b01,
    ROT_RTS = 2'b10
  } mlpm_rot_t;

endpackage : mlpm_pkg

// *** mlpm_top.sv ***
/*
  Motor load protection monitor: current imbalance, low and high torque,
  low and high active power, and supply rotation order at start.
  Settings and status are reached over APB (zero wait states).
  Assumes measurements and run-control levels are synchronous to I_MCLK.
*/
`timescale 1ns/100ps
module mlpm_top import mlpm_pkg::*; #(
  parameter int unsigned CPS = CYCLES_PER_SEC
) (
  // clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_RESETN,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [7:0]        I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // measurement front end
  input  wire logic [MEAS_W-1:0] I_PHASE_R_CURRENT,
  input  wire logic [MEAS_W-1:0] I_PHASE_S_CURRENT,
  input  wire logic [MEAS_W-1:0] I_PHASE_T_CURRENT,
  input  wire logic [TQ_W-1:0]   I_TORQUE_PERCENT_OF_RATED,
  input  wire logic [MEAS_W-1:0] I_MEASURED_ACTIVE_POWER,
  // motor run control
  input  wire logic              I_MOTOR_RUNNING,
  input  wire logic              I_FULL_VOLTAGE,
  input  wire logic              I_START_PULSE,
  input  wire logic              I_ROTATION_IS_RST,
  // protection outcome
  output logic                   O_MOTOR_DISABLE,
  output logic      [NFLT-1:0]   O_FAULT_FLAGS,
  output logic      [NPROT-1:0]  O_ALARM_FLAGS
);

  // configuration and status state
  mlpm_mode_t        mode_r [NPROT];
  logic [THR_W-1:0]  thr_r  [NPROT];
  logic [TIME_W-1:0] time_r [NPROT];
  mlpm_rot_t         rot_r;
  logic [MEAS_W-1:0] rated_i_r;
  logic [MEAS_W-1:0] rated_p_r;
  logic [NFLT-1:0]   fault_r;
  logic [NPROT-1:0]  alarm_r;
  logic              disable_r;
  logic [31:0]       prdata_r;

  // apb phase and address decode
  wire       apb_setup  = I_PSEL && !I_PENABLE;
  wire       apb_access = I_PSEL && I_PENABLE;
  wire       hit_cfg    = (I_PADDR[7:2] <= ADDR_HPW_CFG[7:2]);
  wire       hit_rot    = (I_PADDR[7:2] == ADDR_ROT_CFG[7:2]);
  wire       hit_rated  = (I_PADDR[7:2] == ADDR_RATED[7:2]);
  wire       hit_status = (I_PADDR[7:2] == ADDR_STATUS[7:2]);
  wire       hit_live   = (I_PADDR[7:2] == ADDR_LIVE[7:2]);
  wire       mapped     = hit_cfg | hit_rot | hit_rated | hit_status | hit_live;
  wire [2:0] cfg_idx    = hit_cfg ? I_PADDR[4:2] : 3'h0;
  wire       wr_ok      = apb_access && I_PWRITE && mapped;

  // settings stay frozen while the motor runs
  wire       set_open   = !I_MOTOR_RUNNING;
  wire       wr_rot     = wr_ok && hit_rot && set_open;
  wire       wr_rated   = wr_ok && hit_rated && set_open;
  wire       wr_status  = wr_ok && hit_status;

  // zero wait states; an unmapped word answers with an error
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = apb_access && !mapped;

  // write data fields
  wire [MODE_W-1:0] wd_mode = I_PWDATA[CFG_MODE_LSB +: MODE_W];
  wire [THR_W-1:0]  wd_thr  = I_PWDATA[CFG_THR_LSB +: THR_W];
  wire [TIME_W-1:0] wd_time = I_PWDATA[CFG_TIME_LSB +: TIME_W];
  wire              wd_mode_ok = (wd_mode != 2'b11);
  wire [TIME_W-1:0] wd_time_cl = (wd_time < TIME_MIN) ? TIME_MIN :
                                 (wd_time > TIME_MAX) ? TIME_MAX : wd_time;

  // per-protection settings, one word each
  logic [NPROT-1:0] wr_cfg;
  logic [NPROT-1:0] exceed_raw;
  logic [NPROT-1:0] exceed;
  logic [NPROT-1:0] trip;
  logic [NPROT-1:0] fault_set_p;
  logic [NPROT-1:0] alarm_set;

  genvar k;
  generate
    for (k = 0; k < NPROT; k++) begin : g_prot
      localparam logic [THR_W-1:0] THR_MAX = (k == P_IMB) ? IMB_THR_MAX : LD_THR_MAX;
      localparam logic [THR_W-1:0] THR_DEF = (k == P_IMB) ? IMB_THR_DEF : LD_THR_DEF;

      assign wr_cfg[k] = wr_ok && hit_cfg && (cfg_idx == 3'(k)) && set_open;

      // out-of-range threshold and time writes are pulled to the nearest legal value; a mode of 3 leaves the mode unchanged
      always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          mode_r[k] <= MODE_OFF;
          thr_r[k]  <= THR_DEF;
          time_r[k] <= TIME_DEF;
        end else if (wr_cfg[k]) begin
          mode_r[k] <= wd_mode_ok ? mlpm_mode_t'(wd_mode) : mode_r[k];
          thr_r[k]  <= (wd_thr > THR_MAX) ? THR_MAX : wd_thr;
          time_r[k] <= wd_time_cl;
        end
      end

      // armed only at full voltage after start, and only when enabled
      assign exceed[k] = exceed_raw[k] && I_FULL_VOLTAGE && (mode_r[k] != MODE_OFF);

      mlpm_persist #(
        .CPS      (CPS)
      ) u_persist (
        .i_clk    (I_MCLK),
        .i_resetn (I_RESETN),
        .i_exceed (exceed[k]),
        .i_time_s (time_r[k]),
        .o_trip   (trip[k])
      );

      // trip routed by the programmed action
      assign fault_set_p[k] = trip[k] && (mode_r[k] == MODE_FAULT);
      assign alarm_set[k]   = trip[k] && (mode_r[k] == MODE_ALARM);
    end
  endgenerate

  // rotation order and rated values
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rot_r     <= ROT_OFF;
      rated_i_r <= RATED_I_DEF;
      rated_p_r <= RATED_P_DEF;
    end else begin
      if (wr_rot && (I_PWDATA[1:0] != 2'b11))
        rot_r <= mlpm_rot_t'(I_PWDATA[1:0]);
      if (wr_rated) begin
        rated_i_r <= I_PWDATA[RATED_I_LSB +: MEAS_W];
        rated_p_r <= I_PWDATA[RATED_P_LSB +: MEAS_W];
      end
    end
  end

  // pairwise phase differences, magnitude only
  wire        r_ge_s  = (I_PHASE_R_CURRENT >= I_PHASE_S_CURRENT);
  wire        s_ge_t  = (I_PHASE_S_CURRENT >= I_PHASE_T_CURRENT);
  wire        t_ge_r  = (I_PHASE_T_CURRENT >= I_PHASE_R_CURRENT);
  wire [15:0] d_rs    = r_ge_s ? I_PHASE_R_CURRENT - I_PHASE_S_CURRENT
                               : I_PHASE_S_CURRENT - I_PHASE_R_CURRENT;
  wire [15:0] d_st    = s_ge_t ? I_PHASE_S_CURRENT - I_PHASE_T_CURRENT
                               : I_PHASE_T_CURRENT - I_PHASE_S_CURRENT;
  wire [15:0] d_tr    = t_ge_r ? I_PHASE_T_CURRENT - I_PHASE_R_CURRENT
                               : I_PHASE_R_CURRENT - I_PHASE_T_CURRENT;

  // cross-multiplied so no divider is needed: |a-b|*100 > thr*rated
  wire [23:0] imb_lim = 24'(thr_r[P_IMB]) * 24'(rated_i_r);
  wire [23:0] rs_pct  = 24'(d_rs) * PCT_SCALE;
  wire [23:0] st_pct  = 24'(d_st) * PCT_SCALE;
  wire [23:0] tr_pct  = 24'(d_tr) * PCT_SCALE;
  assign exceed_raw[P_IMB] = (rs_pct > imb_lim) || (st_pct > imb_lim) || (tr_pct > imb_lim);

  // torque is already a percentage of rated torque
  wire [TQ_W:0] tq_pct = {1'b0, I_TORQUE_PERCENT_OF_RATED};
  assign exceed_raw[P_LTQ] = (tq_pct + 11'(thr_r[P_LTQ])) < PCT_FULL;
  assign exceed_raw[P_HTQ] = tq_pct > (PCT_FULL + 11'(thr_r[P_HTQ]));

  // signed power deviation, split into magnitude and side
  wire        p_below = (I_MEASURED_ACTIVE_POWER < rated_p_r);
  wire        p_above = (I_MEASURED_ACTIVE_POWER > rated_p_r);
  wire [15:0] p_diff  = p_below ? rated_p_r - I_MEASURED_ACTIVE_POWER
                                : I_MEASURED_ACTIVE_POWER - rated_p_r;
  wire [23:0] p_pct   = 24'(p_diff) * PCT_SCALE;
  wire [23:0] lpw_lim = 24'(thr_r[P_LPW]) * 24'(rated_p_r);
  wire [23:0] hpw_lim = 24'(thr_r[P_HPW]) * 24'(rated_p_r);
  assign exceed_raw[P_LPW] = p_below && (p_pct > lpw_lim);
  assign exceed_raw[P_HPW] = p_above && (p_pct > hpw_lim);

  // rotation order is judged once per start, never while running
  wire rot_bad = I_START_PULSE &&
                 (((rot_r == ROT_RST) && !I_ROTATION_IS_RST) ||
                  ((rot_r == ROT_RTS) &&  I_ROTATION_IS_RST));

  // sticky flags: write one to clear, a new trip in the same cycle wins
  wire [NFLT-1:0]  fault_set = {rot_bad, fault_set_p};
  wire [NFLT-1:0]  fault_clr = wr_status ? I_PWDATA[ST_FAULT_LSB +: NFLT] : '0;
  wire [NPROT-1:0] alarm_clr = wr_status ? I_PWDATA[ST_ALARM_LSB +: NPROT] : '0;
  wire [NFLT-1:0]  fault_nxt = (fault_r & ~fault_clr) | fault_set;
  wire [NPROT-1:0] alarm_nxt = (alarm_r & ~alarm_clr) | alarm_set;

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fault_r   <= '0;
      alarm_r   <= '0;
      disable_r <= 1'b0;
    end else begin
      fault_r   <= fault_nxt;
      alarm_r   <= alarm_nxt;
      disable_r <= |fault_nxt;
    end
  end

  // read words
  wire [31:0] rd_cfg    = {9'h000, time_r[cfg_idx], 1'b0, thr_r[cfg_idx], 6'h00, mode_r[cfg_idx]};
  wire [31:0] rd_rot    = {30'h00000000, rot_r};
  wire [31:0] rd_rated  = {rated_p_r, rated_i_r};
  wire [31:0] rd_status = {14'h0000, I_FULL_VOLTAGE, disable_r, 3'h0, alarm_r, 2'h0, fault_r};
  wire [31:0] rd_live   = {27'h0000000, exceed};
  wire [31:0] rd_mux    = hit_cfg    ? rd_cfg    :
                          hit_rot    ? rd_rot    :
                          hit_rated  ? rd_rated  :
                          hit_status ? rd_status :
                          hit_live   ? rd_live   : 32'h00000000;

  // read data captured in the setup cycle, held through the access cycle
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN)
      prdata_r <= 32'h00000000;
    else if (apb_setup && !I_PWRITE)
      prdata_r <= rd_mux;
  end

  assign O_PRDATA        = prdata_r;
  assign O_MOTOR_DISABLE = disable_r;
  assign O_FAULT_FLAGS   = fault_r;
  assign O_ALARM_FLAGS   = alarm_r;

endmodule : mlpm_top

// *** testbench.sv ***
/*
  Self-checking bench for the motor load protection monitor.
  Assumes CPS is shortened to 10 cycles per second; APB master speaks at rising edges.
*/
`timescale 1ns/100ps
module testbench import mlpm_pkg::*;;
  localparam int unsigned CPS_T = 10;
  localparam int          LIMIT = 60000;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, run, fv, start, rot, dis;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [MEAS_W-1:0] ph_r, ph_s, ph_t, pw;
  logic [TQ_W-1:0]   tq;
  logic [NFLT-1:0]   fflg;
  logic [NPROT-1:0]  aflg;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  mlpm_top #(.CPS(CPS_T)) mlpm_top_inst (.I_MCLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PHASE_R_CURRENT(ph_r), .I_PHASE_S_CURRENT(ph_s), .I_PHASE_T_CURRENT(ph_t),
    .I_TORQUE_PERCENT_OF_RATED(tq), .I_MEASURED_ACTIVE_POWER(pw), .I_MOTOR_RUNNING(run),
    .I_FULL_VOLTAGE(fv), .I_START_PULSE(start), .I_ROTATION_IS_RST(rot), .O_MOTOR_DISABLE(dis),
    .O_FAULT_FLAGS(fflg), .O_ALARM_FLAGS(aflg));
  mlpm_front mlpm_front_inst (.i_clk(clk), .o_ir(ph_r), .o_is(ph_s), .o_it(ph_t), .o_tq(tq), .o_pw(pw),
    .o_run(run), .o_fv(fv), .o_start(start), .o_rst(rot));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, counted as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // settle past the edge so design updates have landed
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("write pslverr", 32'h0, e);
  endtask : wr
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q);
    chk("read pslverr", experr, e);
  endtask : rd_chk
  task nominal;
    mlpm_front_inst.set_load(16'h0064, 16'h0064, 16'h0064, 10'h064, 16'h0064);
  endtask : nominal
  // stop first so nothing re-trips, then clear and restore the setting
  task cleanup(input logic [7:0] a, input logic [31:0] d);
    nominal();
    mlpm_front_inst.motor_stop();
    wr(ADDR_STATUS, 32'h0000_1F3F);
    wait_cyc(1);
    chk("cleared", 32'h0, {dis, fflg, aflg});
    wr(a, d);
  endtask : cleanup
  task t_regs;
    for (int k = 0; k < NPROT; k++) rd_chk("cfg reset", 8'(k * 4), k == 0 ? 32'h0001_0F00 : 32'h0001_1E00, 1'b0);
    rd_chk("rot reset", ADDR_ROT_CFG, 32'h0, 1'b0);
    rd_chk("rated reset", ADDR_RATED, 32'h0064_0064, 1'b0);
    wr(ADDR_IMB_CFG, 32'h0000_2803);
    rd_chk("clamped cfg", ADDR_IMB_CFG, 32'h0001_1E00, 1'b0);
    rd_chk("unmapped", 8'h24, 32'h0, 1'b1);
    wr(ADDR_IMB_CFG, 32'h0001_0F00);
  endtask : t_regs
  // one excursion per protection; imbalance uses phase T at 80 percent
  task t_trip(input int k, input logic [1:0] md, input int tm);
    logic [THR_W-1:0] thr;
    thr = (k == 0) ? IMB_THR_DEF : LD_THR_DEF;
    wr(8'(k * 4), {9'h000, 7'(tm), 1'b0, thr, 6'h00, md});
    mlpm_front_inst.motor_start(1'b1, 1'b1);
    mlpm_front_inst.set_load(16'h0064, 16'h0064, k == 0 ? 16'h0050 : 16'h0064,
      k == 1 ? 10'h03C : (k == 2 ? 10'h08C : 10'h064), k == 3 ? 16'h003C : (k == 4 ? 16'h008C : 16'h0064));
    wait_cyc(tm * CPS_T - 2);
    chk("early flags", 32'h0, {fflg, aflg});
    wait_cyc(4);
    chk("fault flag", md == MODE_FAULT, fflg[k]);
    chk("alarm flag", md == MODE_ALARM, aflg[k]);
    chk("motor disable", md == MODE_FAULT, dis);
    rd_chk("live excursion", ADDR_LIVE, (md != MODE_OFF) ? (32'h1 << k) : 32'h0, 1'b0);
    cleanup(8'(k * 4), {16'h0001, 1'b0, thr, 8'h00});
  endtask : t_trip
  task t_persist;
    wr(ADDR_LTQ_CFG, 32'h0001_1E01);
    mlpm_front_inst.motor_start(1'b1, 1'b0);
    mlpm_front_inst.set_load(16'h0064, 16'h0064, 16'h0064, 10'h03C, 16'h0064);
    wait_cyc(3 * CPS_T);
    chk("unarmed", 32'h0, fflg);
    mlpm_front_inst.motor_stop();
    mlpm_front_inst.motor_start(1'b1, 1'b1);
    mlpm_front_inst.set_load(16'h0064, 16'h0064, 16'h0064, 10'h046, 16'h0064);
    wait_cyc(2 * CPS_T);
    chk("at threshold", 32'h0, fflg);
    mlpm_front_inst.set_load(16'h0064, 16'h0064, 16'h0064, 10'h03C, 16'h0064);
    wait_cyc(CPS_T - 3);
    nominal();
    mlpm_front_inst.set_load(16'h0064, 16'h0064, 16'h0064, 10'h03C, 16'h0064);
    wait_cyc(CPS_T - 2);
    chk("restarted timer", 32'h0, fflg);
    wait_cyc(4);
    chk("fresh trip", 32'h1, fflg[1]);
    cleanup(ADDR_LTQ_CFG, 32'h0001_1E00);
  endtask : t_persist
  task t_rot;
    wr(ADDR_ROT_CFG, 32'h1);
    mlpm_front_inst.motor_start(1'b0, 1'b1);
    wait_cyc(2);
    chk("rst only", 32'h60, {dis, fflg});
    rd_chk("status word", ADDR_STATUS, 32'h0003_0020, 1'b0);
    cleanup(ADDR_ROT_CFG, 32'h2);
    mlpm_front_inst.motor_start(1'b0, 1'b1);
    wait_cyc(2);
    chk("rts allowed", 32'h0, fflg[5]);
    mlpm_front_inst.motor_stop();
    mlpm_front_inst.motor_start(1'b1, 1'b1);
    wait_cyc(2);
    chk("rts only", 32'h1, fflg[5]);
    cleanup(ADDR_ROT_CFG, 32'h0);
  endtask : t_rot
  initial begin
    rstn = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    for (int k = 0; k < NPROT; k++) begin
      t_trip(k, MODE_FAULT, 1);
      t_trip(k, MODE_ALARM, 2);
    end
    t_trip(1, MODE_OFF, 1);
    t_persist();
    t_rot();
    conclude();
  end
endmodule : testbench
